// file: serial_tx_queue_watermark_irq.v
// Status, watermark and interrupt logic of the serial transmit queue.
// Holds the header mismatch and queue latched status registers, their
// enables, the two watermark values and the combined interrupt request.
// Assumes the host port is synchronous to clk with one-cycle strobes.
// Assumes the fill level, overflow and header inputs come from the same
// clock domain, so none of them is resynchronised here.
`timescale 1ns/1ps
`include "txq_status_map.vh"

module serial_tx_queue_watermark_irq (
  input  wire                   clk,
  input  wire                   rst,
  input  wire [8:0]             host_addr,
  input  wire                   host_wr,
  input  wire                   host_rd,
  input  wire [7:0]             host_wdata,
  output reg  [7:0]             host_rdata,
  output wire                   irq,
  input  wire                   hdr_valid,
  input  wire [7:0]             rx_address_octet,
  input  wire [7:0]             rx_control_octet,
  input  wire [7:0]             rx_sapi_high,
  input  wire [7:0]             rx_sapi_low,
  input  wire [7:0]             expected_address_octet,
  input  wire [7:0]             expected_control_octet,
  input  wire [7:0]             expected_sapi_high,
  input  wire [7:0]             expected_sapi_low,
  input  wire                   fill_update,
  input  wire [`FILL_WIDTH-1:0] fill_level,
  input  wire                   queue_overflow,
  input  wire                   fifo_overflow,
  output wire                   high_watermark_flag,
  output wire                   low_watermark_flag
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [7:0] header_mismatch_irq_enable;
  reg  [7:0] tx_queue_low_watermark;
  reg  [7:0] tx_queue_high_watermark;
  reg  [7:0] tx_queue_irq_enable;
  reg  [3:0] header_mismatch_status;
  reg  [3:0] tx_queue_latched_status;
  reg  [3:0] next_hdr_status;
  reg  [3:0] next_txq_status;
  reg  [3:0] hdr_events;
  reg  [3:0] txq_events;
  wire       high_crossed;
  wire       low_crossed;
  wire       rd_hdr;
  wire       rd_txq;
  wire       wr_hdr_en;
  wire       wr_low_wm;
  wire       wr_high_wm;
  wire       wr_txq_en;

  // Per-octet compare results, qualified later by hdr_valid
  wire       sapi_high_differs;
  wire       sapi_low_differs;
  wire       control_differs;
  wire       address_differs;

  // Named views of the enable and latched bits
  wire       sapi_high_mismatch_irq_en;
  wire       sapi_low_mismatch_irq_en;
  wire       control_mismatch_irq_en;
  wire       address_mismatch_irq_en;
  wire       fifo_overflow_irq_en;
  wire       queue_overflow_irq_en;
  wire       high_watermark_irq_en;
  wire       low_watermark_irq_en;
  wire       sapi_high_mismatch_latched;
  wire       sapi_low_mismatch_latched;
  wire       control_mismatch_latched;
  wire       address_mismatch_latched;
  wire       fifo_overflow_latched;
  wire       queue_overflow_latched;
  wire       high_watermark_latched;
  wire       low_watermark_latched;

  // Enabled latched bits, one term per interrupt source
  wire       sapi_high_req;
  wire       sapi_low_req;
  wire       control_req;
  wire       address_req;
  wire       fifo_ovf_req;
  wire       queue_ovf_req;
  wire       high_wm_req;
  wire       low_wm_req;
  wire       hdr_irq;
  wire       txq_irq;
  wire [7:0] read_value;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function sel;
    input [8:0] a;
    input [8:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  // High when a received octet is not the programmed one
  function octet_differs;
    input [7:0] got;
    input [7:0] want;
    begin
      octet_differs = (got != want);
    end
  endfunction

  // Unmapped offsets return zero rather than a stale register
  function [7:0] read_mux;
    input [8:0] a;
    begin
      case (a)
        `HDR_MISMATCH_STATUS_ADDR: read_mux = {4'h0, header_mismatch_status};
        `HDR_MISMATCH_IRQ_EN_ADDR: read_mux = header_mismatch_irq_enable;
        `TXQ_LOW_WM_ADDR:          read_mux = tx_queue_low_watermark;
        `TXQ_HIGH_WM_ADDR:         read_mux = tx_queue_high_watermark;
        `TXQ_IRQ_EN_ADDR:          read_mux = tx_queue_irq_enable;
        `TXQ_LATCHED_STATUS_ADDR:  read_mux = {4'h0, tx_queue_latched_status};
        default:                   read_mux = 8'h00;
      endcase
    end
  endfunction

  // ****************************************************************
  // Host address decode
  // ****************************************************************
  assign rd_hdr = host_rd && sel(host_addr, `HDR_MISMATCH_STATUS_ADDR);
  assign rd_txq = host_rd && sel(host_addr, `TXQ_LATCHED_STATUS_ADDR);

  assign wr_hdr_en  = host_wr && sel(host_addr, `HDR_MISMATCH_IRQ_EN_ADDR);
  assign wr_low_wm  = host_wr && sel(host_addr, `TXQ_LOW_WM_ADDR);
  assign wr_high_wm = host_wr && sel(host_addr, `TXQ_HIGH_WM_ADDR);
  assign wr_txq_en  = host_wr && sel(host_addr, `TXQ_IRQ_EN_ADDR);

  // ****************************************************************
  // Header octet comparison
  // ****************************************************************
  assign sapi_high_differs = octet_differs(rx_sapi_high, expected_sapi_high);
  assign sapi_low_differs  = octet_differs(rx_sapi_low, expected_sapi_low);
  assign control_differs   =
    octet_differs(rx_control_octet, expected_control_octet);
  assign address_differs   =
    octet_differs(rx_address_octet, expected_address_octet);

  // ****************************************************************
  // Watermark crossing
  // ****************************************************************
  // The fill level is that of the serial-to-Ethernet queue
  wm_crossing u_high (
    .clk         (clk),
    .rst         (rst),
    .fill_update (fill_update),
    .fill_level  (fill_level),
    .threshold   (tx_queue_high_watermark),
    .above       (high_watermark_flag),
    .crossed     (high_crossed)
  );

  wm_crossing u_low (
    .clk         (clk),
    .rst         (rst),
    .fill_update (fill_update),
    .fill_level  (fill_level),
    .threshold   (tx_queue_low_watermark),
    .above       (low_watermark_flag),
    .crossed     (low_crossed)
  );

  // ****************************************************************
  // Event collection and clear-on-read
  // ****************************************************************
  always @* begin
    hdr_events = 4'h0;
    if (hdr_valid) begin
      hdr_events[`BIT_SAPI_HIGH] = sapi_high_differs;
      hdr_events[`BIT_SAPI_LOW]  = sapi_low_differs;
      hdr_events[`BIT_CONTROL]   = control_differs;
      hdr_events[`BIT_ADDRESS]   = address_differs;
    end
    txq_events = 4'h0;
    txq_events[`BIT_FIFO_OVF]  = fifo_overflow;
    txq_events[`BIT_QUEUE_OVF] = queue_overflow;
    txq_events[`BIT_HIGH_WM]   = high_crossed;
    txq_events[`BIT_LOW_WM]    = low_crossed;
    // A new event in the reading cycle survives the clear
    next_hdr_status = (rd_hdr ? 4'h0 : header_mismatch_status) | hdr_events;
    next_txq_status =
      (rd_txq ? 4'h0 : tx_queue_latched_status) | txq_events;
  end

  // Header mismatch status, cleared by its own read only
  always @(posedge clk) begin
    if (rst) begin
      header_mismatch_status <= 4'h0;
    end else begin
      header_mismatch_status <= next_hdr_status;
    end
  end

  // Queue latched status, cleared by its own read only
  always @(posedge clk) begin
    if (rst) begin
      tx_queue_latched_status <= 4'h0;
    end else begin
      tx_queue_latched_status <= next_txq_status;
    end
  end

  // ****************************************************************
  // Host writes
  // ****************************************************************
  // Enable registers keep bits 3:0 only; the upper bits always read zero
  always @(posedge clk) begin
    if (rst) begin
      header_mismatch_irq_enable <= `REG_RESET;
    end else if (wr_hdr_en) begin
      header_mismatch_irq_enable <= {4'h0, host_wdata[3:0]};
    end
  end

  // A new threshold takes effect at the next fill update, not at once
  always @(posedge clk) begin
    if (rst) begin
      tx_queue_low_watermark <= `REG_RESET;
    end else if (wr_low_wm) begin
      tx_queue_low_watermark <= host_wdata;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      tx_queue_high_watermark <= `REG_RESET;
    end else if (wr_high_wm) begin
      tx_queue_high_watermark <= host_wdata;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      tx_queue_irq_enable <= `REG_RESET;
    end else if (wr_txq_en) begin
      tx_queue_irq_enable <= {4'h0, host_wdata[3:0]};
    end
  end

  // ****************************************************************
  // Host reads, registered one cycle after the strobe
  // ****************************************************************
  assign read_value = read_mux(host_addr);

  // Holds the last value read, so software may sample it late
  always @(posedge clk) begin
    if (rst) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      host_rdata <= read_value;
    end
  end

  // ****************************************************************
  // Interrupt request
  // ****************************************************************
  // Enable bits
  assign sapi_high_mismatch_irq_en = header_mismatch_irq_enable[3];
  assign sapi_low_mismatch_irq_en  = header_mismatch_irq_enable[2];
  assign control_mismatch_irq_en   = header_mismatch_irq_enable[1];
  assign address_mismatch_irq_en   = header_mismatch_irq_enable[0];
  assign fifo_overflow_irq_en      = tx_queue_irq_enable[3];
  assign queue_overflow_irq_en     = tx_queue_irq_enable[2];
  assign high_watermark_irq_en     = tx_queue_irq_enable[1];
  assign low_watermark_irq_en      = tx_queue_irq_enable[0];

  // Latched bits
  assign sapi_high_mismatch_latched = header_mismatch_status[3];
  assign sapi_low_mismatch_latched  = header_mismatch_status[2];
  assign control_mismatch_latched   = header_mismatch_status[1];
  assign address_mismatch_latched   = header_mismatch_status[0];
  assign fifo_overflow_latched      = tx_queue_latched_status[3];
  assign queue_overflow_latched     = tx_queue_latched_status[2];
  assign high_watermark_latched     = tx_queue_latched_status[1];
  assign low_watermark_latched      = tx_queue_latched_status[0];

  // Gated sources
  assign sapi_high_req =
    sapi_high_mismatch_latched & sapi_high_mismatch_irq_en;
  assign sapi_low_req  =
    sapi_low_mismatch_latched & sapi_low_mismatch_irq_en;
  assign control_req   =
    control_mismatch_latched & control_mismatch_irq_en;
  assign address_req   =
    address_mismatch_latched & address_mismatch_irq_en;
  assign fifo_ovf_req  =
    fifo_overflow_latched & fifo_overflow_irq_en;
  assign queue_ovf_req =
    queue_overflow_latched & queue_overflow_irq_en;
  assign high_wm_req   =
    high_watermark_latched & high_watermark_irq_en;
  assign low_wm_req    =
    low_watermark_latched & low_watermark_irq_en;

  // Level output: drops once every enabled latched bit is read away
  assign hdr_irq = sapi_high_req | sapi_low_req | control_req | address_req;
  assign txq_irq = fifo_ovf_req | queue_ovf_req | high_wm_req | low_wm_req;
  assign irq     = hdr_irq | txq_irq;

endmodule

// file: serial_tx_queue_watermark_irq_test.sv
// Self-checking bench for the transmit queue status block.
// Assumes the register map header and a 250 MHz clock.
`timescale 1ns/1ps
`include "txq_status_map.vh"
module serial_tx_queue_watermark_irq_test;
  reg                    clk, rst, host_wr, host_rd, hdr_valid;
  reg                    fill_update, queue_overflow, fifo_overflow;
  reg  [8:0]             host_addr;
  reg  [7:0]             host_wdata, ra, rc, rh, rl, ea, ec, eh, el, lo, hi;
  reg  [`FILL_WIDTH-1:0] fill_level;
  wire [7:0]             host_rdata;
  wire                   irq, high_watermark_flag, low_watermark_flag;
  integer                bad_count, checked, seed, i;

  serial_tx_queue_watermark_irq i_dut (.clk, .rst, .host_addr, .host_wr,
    .host_rd, .host_wdata, .host_rdata, .irq, .hdr_valid,
    .rx_address_octet(ra), .rx_control_octet(rc), .rx_sapi_high(rh),
    .rx_sapi_low(rl), .expected_address_octet(ea),
    .expected_control_octet(ec), .expected_sapi_high(eh),
    .expected_sapi_low(el), .fill_update, .fill_level, .queue_overflow,
    .fifo_overflow, .high_watermark_flag, .low_watermark_flag);

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  // ****
  // Tasks
  // ****
  // All strobes are set together once per falling edge, so back-to-back
  // operations never assign a strobe twice in one time step
  task go(input [5:0] s);
    {host_rd, host_wr, hdr_valid, fill_update, queue_overflow,
      fifo_overflow} = s;
    @(negedge clk);
  endtask
  task chk(input string n, input [7:0] e, input [7:0] g);
    checked = checked + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task rd(input [8:0] a, input [7:0] e);
    host_addr = a;
    go(6'h20);
    chk("read data", e, host_rdata);
  endtask
  task wr(input [8:0] a, input [7:0] d);
    {host_addr, host_wdata} = {a, d};
    go(6'h10);
  endtask
  task fill(input [`FILL_WIDTH-1:0] v);
    fill_level = v;
    go(6'h04);
  endtask
  task report_and_stop;
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    {host_rd, host_wr, hdr_valid, fill_update, queue_overflow,
      fifo_overflow, host_addr, host_wdata, fill_level} = 0;
    {ra, rc, rh, rl, ea, ec, eh, el} = 0;
    {rst, seed, bad_count, checked} = {1'b1, 32'd44655, 64'd0};
    repeat (6) @(negedge clk);
    rst = 0;
    for (i = 0; i < 6; i = i + 1)
      rd(9'h122 + i, 8'h00);
    lo = 8'h01 + {$random(seed)} % 100;
    hi = lo + 8'h01 + {$random(seed)} % 100;
    wr(9'h124, lo);
    wr(9'h125, hi);
    wr(9'h126, 8'hff);
    wr(9'h123, 8'hff);
    wr(9'h127, 8'hff);
    rd(9'h124, lo);
    rd(9'h125, hi);
    rd(9'h126, 8'h0f);
    rd(9'h123, 8'h0f);
    rd(9'h127, 8'h00);
    rd(9'h1ff, 8'h00);
    // Each overflow with only the other one's enable, then with its own
    for (i = 0; i < 4; i = i + 1) begin
      wr(9'h126, i[0] ? 8'h04 << i[1] : 8'h08 >> i[1]);
      go({4'h0, ~i[1], i[1]});
      chk("irq", i[0], irq);
      rd(9'h127, 8'h04 << i[1]);
      chk("irq", 0, irq);
      rd(9'h127, 8'h00);
    end
    wr(9'h126, 8'h02);
    fill({lo, 16'h0} - 1);
    chk("low flag", 0, low_watermark_flag);
    fill({lo, 16'h0});
    chk("low flag", 1, low_watermark_flag);
    chk("irq", 0, irq);
    fill({hi, 16'h0} - 1);
    chk("high flag", 0, high_watermark_flag);
    fill({hi, 16'h0});
    chk("irq", 1, irq);
    rd(9'h127, 8'h03);
    fill(0);
    chk("high flag", 0, high_watermark_flag);
    rd(9'h127, 8'h03);
    // Bit i of the header status follows octet i of the mismatch
    for (i = 0; i < 4; i = i + 1) begin
      {ea, ec, el, eh} = $random(seed);
      {ra, rc, rl, rh} = {ea, ec, el, eh} ^ (32'hff << (24 - 8 * i));
      go(6'h08);
      chk("irq", 1, irq);
      rd(9'h122, 8'h01 << i);
      chk("irq", 0, irq);
    end
    go(6'h00);
    report_and_stop;
  end

  // Work takes about 56 cycles; this leaves a wide margin
  initial begin
    #5000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule

// file: txq_status_map.vh
// Register map, field positions, reset values and sizing constants for the
// serial-side transmit queue status and interrupt block.
// Assumes an 8-bit host processor port with byte-wide registers.
//
// What this block does
// - Header enable bit 3 lets the SAPI high mismatch raise the interrupt.
// - Header enable bit 2 lets the SAPI low mismatch raise the interrupt.
// - Header enable bit 1 lets the control mismatch raise the interrupt.
// - Header enable bit 0 lets the address mismatch raise the interrupt.
// - Low watermark byte position is the low value times 32 times 2048.
// - High watermark byte position is the high value times 32 times 2048.
// - Watermarks watch the queue from the serial side towards Ethernet.
// - Queue enable bits 3 and 2 gate the FIFO and queue overflow latches.
// - Queue enable bits 1 and 0 gate the high and low watermark latches.
// - Latched bit 1 sets when the fill level crosses the high watermark.
// - Latched bit 0 sets when the fill level crosses the low watermark.
// - Latched bit 2 sets when the transmit queue overflows.
// - Latched bit 3 sets when the decapsulator-to-SDRAM FIFO overflows.
// - Reading the queue latched status returns the bits, then clears them.
// - A header mismatch latches on a differing octet and clears on read.
`ifndef TXQ_STATUS_MAP_VH
`define TXQ_STATUS_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define HDR_MISMATCH_STATUS_ADDR 9'h122
`define HDR_MISMATCH_IRQ_EN_ADDR 9'h123
`define TXQ_LOW_WM_ADDR          9'h124
`define TXQ_HIGH_WM_ADDR         9'h125
`define TXQ_IRQ_EN_ADDR          9'h126
`define TXQ_LATCHED_STATUS_ADDR  9'h127

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_SAPI_HIGH   3
`define BIT_SAPI_LOW    2
`define BIT_CONTROL     1
`define BIT_ADDRESS     0
`define BIT_FIFO_OVF    3
`define BIT_QUEUE_OVF   2
`define BIT_HIGH_WM     1
`define BIT_LOW_WM      0

// ****************************************************************
// Reset values and sizing
// ****************************************************************
`define REG_RESET       8'h00
`define WM_PACKETS      32
`define WM_PACKET_BYTES 2048
`define WM_SHIFT        16
`define FILL_WIDTH      24

`endif

// file: txq_status_sva.sv
// Checker for the transmit queue status block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module txq_status_sva (
  input wire       clk,
  input wire       rst,
  input wire [8:0] host_addr,
  input wire       host_wr,
  input wire       host_rd,
  input wire [7:0] host_rdata,
  input wire       irq,
  input wire       hdr_valid,
  input wire [7:0] rx_address_octet,
  input wire [7:0] expected_address_octet,
  input wire       fill_update,
  input wire       queue_overflow,
  input wire       fifo_overflow,
  input wire       high_watermark_flag,
  input wire       low_watermark_flag
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire st_rd = host_rd && host_addr == 9'h127;
  wire ev    = queue_overflow || fifo_overflow || fill_update;

  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !irq && host_rdata == 8'h00) else $error("reset not clean");
  a_qovf_latch: assert property (
    queue_overflow ##1 st_rd |=> host_rdata[2]) else $error("qovf lost");
  a_fovf_latch: assert property (
    fifo_overflow ##1 st_rd |=> host_rdata[3]) else $error("fovf lost");
  a_read_clears: assert property (
    st_rd && !ev ##1 st_rd |=> host_rdata == 8'h00) else $error("no clear");
  a_flags_hold: assert property (
    !fill_update |=> $stable({high_watermark_flag, low_watermark_flag}))
    else $error("flag moved");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(ev || hdr_valid || host_wr)) else $error("irq rose");
  a_irq_drop: assert property (
    $fell(irq) |-> $past(host_rd || host_wr)) else $error("irq fell");
  a_addr_mismatch: assert property (
    hdr_valid && rx_address_octet != expected_address_octet ##1
    host_rd && host_addr == 9'h122 |=> host_rdata[0]) else $error("addr");
endmodule

bind serial_tx_queue_watermark_irq txq_status_sva i_sva (.clk, .rst,
  .host_addr, .host_wr, .host_rd, .host_rdata, .irq, .hdr_valid,
  .rx_address_octet, .expected_address_octet, .fill_update,
  .queue_overflow, .fifo_overflow, .high_watermark_flag, .low_watermark_flag);

// file: wm_crossing.v
// One watermark crossing detector for the transmit queue fill level.
// Assumes fill level updates are marked by a one-cycle strobe.
`timescale 1ns/1ps
`include "txq_status_map.vh"

module wm_crossing (
  input  wire                     clk,
  input  wire                     rst,
  input  wire                     fill_update,
  input  wire [`FILL_WIDTH-1:0]   fill_level,
  input  wire [7:0]               threshold,
  output reg                      above,
  output wire                     crossed
);

  // 2048 * 32 = 2^16, so the byte position is a plain shift
  wire [`FILL_WIDTH-1:0] position;
  wire                   next_above;

  assign position   = {threshold, 16'h0000};
  assign next_above = (fill_level >= position);

  // Either direction counts, once per transition
  assign crossed = fill_update && (next_above != above);

  always @(posedge clk) begin
    if (rst) begin
      above <= 1'b0;
    end else if (fill_update) begin
      above <= next_above;
    end
  end

endmodule
